// ---- inc/csfr_pkg.sv ----
// Constants and types shared by the core special-register block
package csfr_pkg;

   // Direct file addresses of the special registers
   localparam logic [4:0] CSFR_INDIRECT_ADDR = 5'h00;
   localparam logic [4:0] CSFR_TIMER_ADDR    = 5'h01;
   localparam logic [4:0] CSFR_PCL_ADDR      = 5'h02;
   localparam logic [4:0] CSFR_STATUS_ADDR   = 5'h03;
   localparam logic [4:0] CSFR_POINTER_ADDR  = 5'h04;
   localparam logic [4:0] CSFR_PORT1_ADDR    = 5'h05;
   localparam logic [4:0] CSFR_PORT2_ADDR    = 5'h06;
   localparam logic [4:0] CSFR_PORT3_ADDR    = 5'h07;
   localparam logic [4:0] CSFR_UPPER_ADDR    = 5'h10;

   // Status register field positions
   localparam int CSFR_CARRY_BIT  = 0;
   localparam int CSFR_NIBBLE_BIT = 1;
   localparam int CSFR_ZERO_BIT   = 2;
   localparam int CSFR_SLEEP_BIT  = 3;
   localparam int CSFR_WDOG_BIT   = 4;
   localparam int CSFR_BANK_LO    = 5;
   localparam int CSFR_BANK_HI    = 6;

   // Indirect pointer field positions
   localparam int CSFR_PTR_BANK_LO = 5;
   localparam int CSFR_PTR_FIXED   = 7;

   // Values after reset
   localparam logic [7:0] CSFR_STATUS_RST = 8'h18;
   localparam logic [7:0] CSFR_POINTER_RST = 8'h80;
   localparam logic [3:0] CSFR_DIR_RST    = 4'hf;
   localparam logic [7:0] CSFR_PORT_RST   = 8'h00;

   // Storage: bank 0 keeps 32 words, each further bank 16
   localparam int CSFR_BANK_WORDS = 16;
   localparam int CSFR_RAM_WORDS  = 80;

   // Operations offered by the flag unit
   typedef enum logic [2:0] {
      CSFR_OP_ADD,
      CSFR_OP_SUB,
      CSFR_OP_AND,
      CSFR_OP_IOR,
      CSFR_OP_XOR,
      CSFR_OP_MOVE,
      CSFR_OP_ROT_LEFT,
      CSFR_OP_ROT_RIGHT
   } csfr_op_t;

endpackage : csfr_pkg

// ---- tb/csfr_regs_asserts.sv ----
// Checker for the core special-register block, bound to its ports
`timescale 1ns/10ps
module csfr_regs_chk
   import csfr_pkg::*;
#(
   parameter int PC_W = 11
) (
   // Clock and resets
   input wire logic            clk_i,
   input wire logic            sys_rst_i,
   input wire logic            ext_rst_i,
   // File access
   input wire logic [4:0]      f_addr_i,
   input wire logic            f_rd_i,
   input wire logic            f_wr_i,
   input wire logic [7:0]      f_rdata_o,
   input wire logic            f_rvalid_o,
   // Flag unit
   input wire logic            alu_en_i,
   input wire csfr_op_t        alu_op_i,
   input wire logic [7:0]      alu_file_i,
   input wire logic [7:0]      alu_work_i,
   input wire logic [7:0]      alu_res_o,
   // Stack
   input wire logic            call_i,
   input wire logic            ret_i,
   input wire logic [PC_W-1:0] pc_i,
   input wire logic            pc_load_o,
   input wire logic [PC_W-1:0] pc_load_val_o,
   // Power, pages and direction
   input wire logic            sleep_op_i,
   input wire logic            wdt_timeout_i,
   input wire logic            asleep_o,
   input wire logic [1:0]      program_bank_bits_o,
   input wire logic            direction_load_op_i,
   input wire logic [4:0]      dir_addr_i,
   input wire logic [7:0]      work_i,
   input wire logic [3:0]      first_port_io_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // A lone return must give exactly one load pulse
   sequence s_lone_ret;
      ret_i && !call_i ##1 !ret_i;
   endsequence
   sequence s_call_ret;
      call_i && !ret_i ##1 !call_i && !ret_i ##1 ret_i && !call_i;
   endsequence

   a_ptr_msb_one: assert property (
      f_rd_i && f_addr_i == CSFR_POINTER_ADDR |=> f_rvalid_o && f_rdata_o[7])
      else $error("pointer top bit read as zero");
   a_port_upper_zero: assert property (
      f_rd_i && f_addr_i == CSFR_PORT1_ADDR |=> f_rdata_o[7:4] == 4'h0)
      else $error("first port upper bits not zero");
   a_ret_load_pulse: assert property (
      s_lone_ret |-> pc_load_o ##1 !pc_load_o)
      else $error("return load pulse wrong");
   a_call_ret_addr: assert property (
      s_call_ret |=> pc_load_val_o == PC_W'($past(pc_i, 3) + 1'b1))
      else $error("return address not call address plus one");
   a_dir_load_oe: assert property (
      direction_load_op_i && dir_addr_i == CSFR_PORT1_ADDR && !ext_rst_i
      && !wdt_timeout_i |=> first_port_io_oe_o == ~$past(work_i[3:0]))
      else $error("output enables differ from loaded direction");
   a_dir_hold_oe: assert property (
      !direction_load_op_i && !ext_rst_i && !wdt_timeout_i
      |=> $stable(first_port_io_oe_o))
      else $error("output enables changed without a load");
   a_sleep_asleep: assert property (
      sleep_op_i && !wdt_timeout_i && !ext_rst_i |=> asleep_o)
      else $error("sleep operation did not enter sleep");
   a_add_sum: assert property (
      alu_en_i && alu_op_i == CSFR_OP_ADD
      |=> alu_res_o == 8'($past(alu_file_i) + $past(alu_work_i)))
      else $error("addition result wrong");
   a_sub_diff: assert property (
      alu_en_i && alu_op_i == CSFR_OP_SUB
      |=> alu_res_o == 8'($past(alu_file_i) - $past(alu_work_i)))
      else $error("subtraction result wrong");
   a_page_ext_rst: assert property (
      ext_rst_i && !f_wr_i |=> program_bank_bits_o == 2'b00)
      else $error("page bits kept over external reset");
endmodule : csfr_regs_chk

bind csfr_regs csfr_regs_chk #(.PC_W(PC_W)) csfr_regs_chk_inst (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ext_rst_i(ext_rst_i),
   .f_addr_i(f_addr_i), .f_rd_i(f_rd_i), .f_wr_i(f_wr_i),
   .f_rdata_o(f_rdata_o), .f_rvalid_o(f_rvalid_o), .alu_en_i(alu_en_i),
   .alu_op_i(alu_op_i), .alu_file_i(alu_file_i), .alu_work_i(alu_work_i),
   .alu_res_o(alu_res_o), .call_i(call_i), .ret_i(ret_i), .pc_i(pc_i),
   .pc_load_o(pc_load_o), .pc_load_val_o(pc_load_val_o),
   .sleep_op_i(sleep_op_i), .wdt_timeout_i(wdt_timeout_i),
   .asleep_o(asleep_o), .program_bank_bits_o(program_bank_bits_o),
   .direction_load_op_i(direction_load_op_i), .dir_addr_i(dir_addr_i),
   .work_i(work_i), .first_port_io_oe_o(first_port_io_oe_o));

// ---- tb/tb_top.sv ----
// Self-checking bench for the core special-register block
`timescale 1ns/10ps
module tb_top
   import csfr_pkg::*;
;
   // Stimulus; events: sleep, clear, wdt, ext, call, ret, dir load
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [4:0]  f_addr_i = '0;
   logic        f_rd_i = 1'b0;
   logic        f_wr_i = 1'b0;
   logic [7:0]  f_wdata_i = '0;
   logic        alu_en_i = 1'b0;
   csfr_op_t    alu_op_i = CSFR_OP_ADD;
   logic [7:0]  alu_file_i = '0;
   logic [7:0]  alu_work_i = '0;
   logic [10:0] pc_i = '0;
   logic [6:0]  ev_v = '0;
   logic [4:0]  dir_addr_i = '0;
   logic [7:0]  work_i = '0;
   logic [3:0]  pins = '0;
   // Observed outputs
   logic [7:0]  f_rdata_o, alu_res_o, port2_o, port3_o;
   logic        f_rvalid_o, ext_sel_o, pc_load_o, asleep_o;
   logic [10:0] pc_load_val_o;
   logic [1:0]  bank_o;
   logic [3:0]  p1_o, p1_oe_o;
   int          err_count = 0;
   int          total_checks = 0;

   // Flag unit cases; carry feeds the rotates, so order matters
   localparam csfr_op_t AOP [9] = '{CSFR_OP_ADD, CSFR_OP_SUB, CSFR_OP_ADD,
      CSFR_OP_AND, CSFR_OP_ROT_LEFT, CSFR_OP_ROT_RIGHT, CSFR_OP_XOR,
      CSFR_OP_IOR, CSFR_OP_MOVE};
   localparam logic [7:0] AF [9] = '{8'hFF, 8'h05, 8'h0F, 8'hF0, 8'h81,
      8'h02, 8'h55, 8'h00, 8'h33};
   localparam logic [7:0] AW [9] = '{8'h01, 8'h05, 8'h01, 8'h0F, 8'h81,
      8'h02, 8'h55, 8'h00, 8'h33};
   localparam logic [7:0] AR [9] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h02,
      8'h81, 8'h00, 8'h00, 8'h33};
   localparam logic [7:0] AS [9] = '{8'h1F, 8'h1F, 8'h1A, 8'h1E, 8'h1F,
      8'h1E, 8'h1E, 8'h1E, 8'h1A};
   // Power events and the status expected after each
   localparam int PEV [7] = '{0, 2, 1, 2, 0, 3, 1};
   localparam logic [7:0] PST [7] = '{8'h12, 8'h02, 8'h1A, 8'h0A, 8'h12,
      8'h12, 8'h1A};
   // Register script: bit 15 read and compare, 12:8 address, 7:0 data
   localparam logic [15:0] SCR [21] = '{16'h0425, 16'h84A5, 16'h0410,
      16'h1011, 16'h0430, 16'h005A, 16'h805A, 16'h905A, 16'h0410,
      16'h8011, 16'h0428, 16'h00C3, 16'h0408, 16'h80C3, 16'h88C3,
      16'h0400, 16'h0077, 16'h8000, 16'h8480, 16'h07A5, 16'h87A5};

   csfr_regs csfr_regs_inst (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ext_rst_i(ev_v[3]),
      .f_addr_i(f_addr_i), .f_rd_i(f_rd_i), .f_wr_i(f_wr_i),
      .f_wdata_i(f_wdata_i), .f_rdata_o(f_rdata_o), .f_rvalid_o(f_rvalid_o),
      .ext_sel_o(ext_sel_o), .ext_rdata_i(8'h00), .alu_en_i(alu_en_i),
      .alu_op_i(alu_op_i), .alu_file_i(alu_file_i), .alu_work_i(alu_work_i),
      .alu_res_o(alu_res_o), .call_i(ev_v[4]), .ret_i(ev_v[5]), .pc_i(pc_i),
      .pc_load_o(pc_load_o), .pc_load_val_o(pc_load_val_o),
      .sleep_op_i(ev_v[0]), .watchdog_clear_op_i(ev_v[1]),
      .wdt_timeout_i(ev_v[2]), .asleep_o(asleep_o),
      .program_bank_bits_o(bank_o), .direction_load_op_i(ev_v[6]),
      .dir_addr_i(dir_addr_i), .work_i(work_i), .first_port_io_i(pins),
      .first_port_io_o(p1_o), .first_port_io_oe_o(p1_oe_o),
      .second_port_io_o(port2_o), .third_port_io_o(port3_o));

   // Clock, 4 ns period
   initial forever #2 clk_i = ~clk_i;

   task automatic compare(input string nm, input logic [15:0] exp,
                          input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : compare

   // Read: strobe one cycle, data lands one edge later
   task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      f_addr_i <= a;
      f_rd_i <= 1'b1;
      @(posedge clk_i);
      f_rd_i <= 1'b0;
      #1;
      compare("read data", exp, f_rdata_o);
   endtask : rdc

   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge clk_i);
      f_addr_i <= a;
      f_wdata_i <= v;
      f_wr_i <= 1'b1;
      @(posedge clk_i);
      f_wr_i <= 1'b0;
   endtask : wr

   // One-cycle event pulse; v also serves as pc and working value
   task automatic ev(input int k, input logic [7:0] v, input logic [4:0] a);
      @(posedge clk_i);
      ev_v <= 7'(1 << k);
      pc_i <= {3'b000, v};
      work_i <= v;
      dir_addr_i <= a;
      @(posedge clk_i);
      ev_v <= '0;
      #1;
   endtask : ev

   task automatic alu(input int i);
      @(posedge clk_i);
      alu_en_i <= 1'b1;
      alu_op_i <= AOP[i];
      alu_file_i <= AF[i];
      alu_work_i <= AW[i];
      @(posedge clk_i);
      alu_en_i <= 1'b0;
      #1;
      compare("flag unit result", AR[i], alu_res_o);
   endtask : alu

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   // Hang guard, far beyond the roughly 150 cycles the tests take
   initial begin
      repeat (5000) @(posedge clk_i);
      err_count++;
      test_done();
   end

   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rdc(CSFR_STATUS_ADDR, 8'h18);
      rdc(CSFR_POINTER_ADDR, 8'h80);
      compare("output enables", 4'h0, p1_oe_o);
      // Page bits writable, flags 3 and 4 and bit 7 are not
      wr(CSFR_STATUS_ADDR, 8'hFF);
      rdc(CSFR_STATUS_ADDR, 8'h7F);
      compare("page bits", 2'b11, bank_o);
      ev(3, 8'h00, 5'h00);
      rdc(CSFR_STATUS_ADDR, 8'h1F);
      wr(CSFR_STATUS_ADDR, 8'h00);
      for (int i = 0; i < 9; i++) begin
         alu(i);
         rdc(CSFR_STATUS_ADDR, AS[i]);
      end
      for (int i = 0; i < 7; i++) begin
         ev(PEV[i], 8'h00, 5'h00);
         if (i == 0) compare("asleep", 1'b1, asleep_o);
         rdc(CSFR_STATUS_ADDR, PST[i]);
      end
      // Two calls then three returns; level two is reused
      ev(4, 8'h05, 5'h00);
      ev(4, 8'h09, 5'h00);
      for (int i = 0; i < 3; i++) begin
         ev(5, 8'h00, 5'h00);
         compare("return address", (i == 0) ? 11'h00A : 11'h006,
                 pc_load_val_o);
      end
      compare("load pulse", 1'b1, pc_load_o);
      for (int i = 0; i < 21; i++) begin
         if (SCR[i][15]) rdc(SCR[i][12:8], SCR[i][7:0]);
         else wr(SCR[i][12:8], SCR[i][7:0]);
      end
      compare("third port", 8'hA5, port3_o);
      ev(6, 8'h05, CSFR_PORT1_ADDR);
      compare("output enables", 4'hA, p1_oe_o);
      ev(6, 8'h00, CSFR_PORT2_ADDR);
      compare("output enables", 4'hA, p1_oe_o);
      @(posedge clk_i);
      pins <= 4'h9;
      repeat (6) @(posedge clk_i);
      rdc(CSFR_PORT1_ADDR, 8'h09);
      wr(CSFR_PORT1_ADDR, 8'hF6);
      wr(CSFR_PORT2_ADDR, 8'h3C);
      #1;
      compare("first port latch", 4'h6, p1_o);
      compare("second port", 8'h3C, port2_o);
      rdc(CSFR_PORT1_ADDR, 8'h09);
      test_done();
   end
endmodule : tb_top

// ---- verilog/csfr_alu_flags.sv ----
// Arithmetic unit computing a result and its status flags
`timescale 1ns/10ps
module csfr_alu_flags
   import csfr_pkg::*;
(
   // Operands and operation
   input  wire csfr_op_t   op_i,
   input  wire logic [7:0] file_i,
   input  wire logic [7:0] work_i,
   input  wire logic       carry_i,
   // Result and flags
   output logic [7:0]      res_o,
   output logic            carry_o,
   output logic            nibble_o,
   output logic            zero_o,
   output logic            carry_upd_o,
   output logic            nibble_upd_o,
   output logic            zero_upd_o
);

   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] addend;
   logic       cin;

   // Subtraction adds the two's complement of the working value
   always_comb begin
      addend = (op_i == CSFR_OP_SUB) ? ~work_i : work_i;
      cin    = (op_i == CSFR_OP_SUB);
      sum     = {1'b0, file_i} + {1'b0, addend} + {8'h00, cin};
      low_sum = {1'b0, file_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
   end

   // Result and flag selection per operation
   always_comb begin
      res_o        = file_i;
      carry_o      = carry_i;
      nibble_o     = 1'b0;
      carry_upd_o  = 1'b0;
      nibble_upd_o = 1'b0;
      zero_upd_o   = 1'b1;
      case (op_i)
         CSFR_OP_ADD, CSFR_OP_SUB: begin
            res_o        = sum[7:0];
            // (RULE3) carry from bit 7
            carry_o      = sum[8];
            // (RULE5) carry from bit 3
            nibble_o     = low_sum[4];
            carry_upd_o  = 1'b1;
            nibble_upd_o = 1'b1;
         end
         CSFR_OP_AND:  res_o = file_i & work_i;
         CSFR_OP_IOR:  res_o = file_i | work_i;
         CSFR_OP_XOR:  res_o = file_i ^ work_i;
         CSFR_OP_MOVE: res_o = file_i;
         // (RULE4) rotate through carry
         CSFR_OP_ROT_LEFT: begin
            res_o       = {file_i[6:0], carry_i};
            carry_o     = file_i[7];
            carry_upd_o = 1'b1;
            zero_upd_o  = 1'b0;
         end
         CSFR_OP_ROT_RIGHT: begin
            res_o       = {carry_i, file_i[7:1]};
            carry_o     = file_i[0];
            carry_upd_o = 1'b1;
            zero_upd_o  = 1'b0;
         end
         default: zero_upd_o = 1'b0;
      endcase
   end

   // (RULE6) zero result flag
   assign zero_o = (res_o == 8'h00);

endmodule : csfr_alu_flags

// ---- verilog/csfr_regs.sv ----
// Special registers of the core: stack, status, pointer, first port
// Operation
// (RULE1) Return loads PC from stack level one, then level two into one.
// (RULE2) Call pushes level one into two, then incremented PC into one.
// (RULE3) Carry flag, status bit 0, set on carry out of bit 7.
// (RULE4) Rotates shift through the carry flag.
// (RULE5) Nibble carry flag, status bit 1, set on carry out of bit 3.
// (RULE6) Zero flag, status bit 2, set when result is zero.
// (RULE7) Sleep flag bit 3 set at power-up and watchdog clear; sleep clears.
// (RULE8) Watchdog flag bit 4 set by power-up, clear, sleep; timeout clears.
// (RULE9) Watchdog reset awake gives sleep 1, watchdog 0; power-up both 1.
// (RULE10) External reset in sleep sets watchdog flag; watchdog reset clears.
// (RULE11) Status bits 5-6 are program page bits; two-page uses bit 5.
// (RULE12) Pointer bits 0-4 select one of 32 registers in a bank.
// (RULE13) Pointer bits 5-6 select one of four banks on big variant.
// (RULE14) Lower 16 registers of each bank alias bank 0 registers.
// (RULE15) Pointer bit 7 is read-only and reads one.
// (RULE16) Every register is reachable by indirect access.
// (RULE17) Address 00h means indirect; indirect 00h reads 0, write ignored.
// (RULE18) Port register reads return pin levels, not latched values.
// (RULE19) Port is 4 bits; upper four bits read zero.
// (RULE20) Without third port, address 07h is plain storage.
// (RULE21) Direction bit 1 makes pin input, 0 makes it drive.
// (RULE22) Direction loaded only by a dedicated op for addresses 05h-07h; here only 05h has a direction register.
// (RULE23) Return leaves stack level two unchanged.
`timescale 1ns/10ps
module csfr_regs
   import csfr_pkg::*;
#(
   parameter int PC_W       = 11,
   parameter int NUM_PAGES  = 4,
   parameter int NUM_BANKS  = 4,
   parameter bit HAS_PORT3  = 1'b1
) (
   // Clock and resets
   input  wire logic            clk_i,
   input  wire logic            sys_rst_i,
   input  wire logic            ext_rst_i,
   // File access from the core
   input  wire logic [4:0]      f_addr_i,
   input  wire logic            f_rd_i,
   input  wire logic            f_wr_i,
   input  wire logic [7:0]      f_wdata_i,
   output logic [7:0]           f_rdata_o,
   output logic                 f_rvalid_o,
   // Registers kept outside this block (timer, program counter low)
   output logic                 ext_sel_o,
   input  wire logic [7:0]      ext_rdata_i,
   // Flag unit operation
   input  wire logic            alu_en_i,
   input  wire csfr_op_t        alu_op_i,
   input  wire logic [7:0]      alu_file_i,
   input  wire logic [7:0]      alu_work_i,
   output logic [7:0]           alu_res_o,
   // Subroutine stack
   input  wire logic            call_i,
   input  wire logic            ret_i,
   input  wire logic [PC_W-1:0] pc_i,
   output logic                 pc_load_o,
   output logic [PC_W-1:0]      pc_load_val_o,
   // Power and watchdog events
   input  wire logic            sleep_op_i,
   input  wire logic            watchdog_clear_op_i,
   input  wire logic            wdt_timeout_i,
   output logic                 asleep_o,
   output logic [1:0]           program_bank_bits_o,
   // Direction load operation
   input  wire logic            direction_load_op_i,
   input  wire logic [4:0]      dir_addr_i,
   input  wire logic [7:0]      work_i,
   // First port pins
   input  wire logic [3:0]      first_port_io_i,
   output logic [3:0]           first_port_io_o,
   output logic [3:0]           first_port_io_oe_o,
   // Second and third port latches
   output logic [7:0]           second_port_io_o,
   output logic [7:0]           third_port_io_o
);

   // File address to word index
   function automatic logic [6:0] ram_index(input logic [6:0] a);
      // (RULE14) lower half aliases bank 0
      return a[4] ? 7'(CSFR_BANK_WORDS) + {1'b0, a[6:5], a[3:0]}
                  : {3'b000, a[3:0]};
   endfunction : ram_index

   logic [7:0]      status_q;
   logic [7:0]      pointer_q;
   logic [3:0]      port1_out_q;
   logic [3:0]      first_port_direction_q;
   logic [7:0]      port2_q;
   logic [7:0]      port3_q;
   logic [PC_W-1:0] stk1_q;
   logic [PC_W-1:0] stk2_q;
   logic            asleep_q;
   logic [3:0]      pin_s1_q;
   logic [3:0]      pin_s2_q;
   logic [3:0]      pin_s3_q;
   logic [3:0]      pin_lvl_q;
   logic [7:0]      ram_q [CSFR_RAM_WORDS];

   logic [6:0]  eff_addr;
   logic        is_ind;
   logic        null_ind;
   logic        wr_en;
   logic        wr_ram;
   logic        wdt_reset;
   logic        hw_reset;
   logic [7:0]  alu_res;
   logic        alu_c;
   logic        alu_dc;
   logic        alu_z;
   logic        alu_c_upd;
   logic        alu_dc_upd;
   logic        alu_z_upd;
   logic [1:0]  bank_sel;
   logic [7:0]  rd_mux;

   // Flag unit
   csfr_alu_flags u_alu (
      .op_i         (alu_op_i),
      .file_i       (alu_file_i),
      .work_i       (alu_work_i),
      .carry_i      (status_q[CSFR_CARRY_BIT]),
      .res_o        (alu_res),
      .carry_o      (alu_c),
      .nibble_o     (alu_dc),
      .zero_o       (alu_z),
      .carry_upd_o  (alu_c_upd),
      .nibble_upd_o (alu_dc_upd),
      .zero_upd_o   (alu_z_upd)
   );

   // Bank bits only exist on the four-bank variant
   assign bank_sel = (NUM_BANKS == 4) ? pointer_q[6:5] : 2'b00;

   // Effective address, direct or via the pointer
   always_comb begin
      // (RULE17) address 00h goes indirect
      is_ind = (f_addr_i == CSFR_INDIRECT_ADDR);
      // (RULE12) low five bits pick the register
      // (RULE16) pointer reaches every register
      eff_addr = is_ind ? {bank_sel, pointer_q[4:0]}
                        : {bank_sel, f_addr_i};
      null_ind = is_ind && (pointer_q[4:0] == CSFR_INDIRECT_ADDR);
      wr_en    = f_wr_i && !null_ind;
      wr_ram   = wr_en && (eff_addr[4:0] > CSFR_PORT3_ADDR);
   end

   // Timer and program counter low live outside this block
   assign ext_sel_o = (f_rd_i || f_wr_i) && !null_ind &&
                      ((eff_addr[4:0] == CSFR_TIMER_ADDR) ||
                       (eff_addr[4:0] == CSFR_PCL_ADDR));

   // A watchdog timeout while awake resets the core
   assign wdt_reset = wdt_timeout_i && !asleep_q;
   assign hw_reset  = ext_rst_i || wdt_reset;

   // Read data selection
   always_comb begin
      rd_mux = 8'h00;
      case (eff_addr[4:0])
         CSFR_TIMER_ADDR, CSFR_PCL_ADDR: rd_mux = ext_rdata_i;
         CSFR_STATUS_ADDR:  rd_mux = status_q;
         // (RULE15) bit 7 always one
         CSFR_POINTER_ADDR: rd_mux = pointer_q | 8'h80;
         // (RULE18) pins, not latch
         // (RULE19) upper nibble zero
         CSFR_PORT1_ADDR:   rd_mux = {4'h0, pin_lvl_q};
         CSFR_PORT2_ADDR:   rd_mux = port2_q;
         CSFR_PORT3_ADDR:   rd_mux = port3_q;
         default:           rd_mux = ram_q[ram_index(eff_addr)];
      endcase
      if (null_ind) begin
         rd_mux = 8'h00;
      end
   end

   // Read return registered, one cycle after the request
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         f_rdata_o  <= 8'h00;
         f_rvalid_o <= 1'b0;
      end else begin
         f_rvalid_o <= f_rd_i;
         if (f_rd_i) begin
            f_rdata_o <= rd_mux;
         end
      end
   end

   // General purpose storage, left unreset
   always_ff @(posedge clk_i) begin
      if (wr_ram) begin
         ram_q[ram_index(eff_addr)] <= f_wdata_i;
      end
   end

   // Registered flag unit result
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         alu_res_o <= 8'h00;
      end else if (alu_en_i) begin
         alu_res_o <= alu_res;
      end
   end

   // Status arithmetic flags and page bits; unit flags win over a write
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         status_q[2:0] <= CSFR_STATUS_RST[2:0];
         status_q[7:5] <= CSFR_STATUS_RST[7:5];
      end else begin
         if (hw_reset) begin
            status_q[7:5] <= CSFR_STATUS_RST[7:5];
         end else if (wr_en && eff_addr[4:0] == CSFR_STATUS_ADDR) begin
            // (RULE11) page bits; bit 6 only with four pages
            status_q[CSFR_BANK_LO] <= (NUM_PAGES > 1) && f_wdata_i[5];
            status_q[CSFR_BANK_HI] <= (NUM_PAGES == 4) && f_wdata_i[6];
            status_q[7]            <= 1'b0;
            status_q[2:0]          <= f_wdata_i[2:0];
         end
         if (alu_en_i) begin
            // (RULE3) carry update
            // (RULE4) rotate carry update
            if (alu_c_upd) begin
               status_q[CSFR_CARRY_BIT] <= alu_c;
            end
            // (RULE5) nibble carry update
            if (alu_dc_upd) begin
               status_q[CSFR_NIBBLE_BIT] <= alu_dc;
            end
            // (RULE6) zero flag update
            if (alu_z_upd) begin
               status_q[CSFR_ZERO_BIT] <= alu_z;
            end
         end
      end
   end

   // Sleep and watchdog flags; software cannot write them
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         // (RULE7) power-up sets sleep flag
         // (RULE8) power-up sets watchdog flag
         status_q[CSFR_SLEEP_BIT] <= CSFR_STATUS_RST[CSFR_SLEEP_BIT];
         status_q[CSFR_WDOG_BIT]  <= CSFR_STATUS_RST[CSFR_WDOG_BIT];
      end else if (wdt_timeout_i) begin
         // (RULE8) timeout clears watchdog flag
         // (RULE9) awake watchdog reset
         status_q[CSFR_WDOG_BIT] <= 1'b0;
         if (!asleep_q) begin
            status_q[CSFR_SLEEP_BIT] <= 1'b1;
         end
      end else if (ext_rst_i) begin
         // (RULE10) external reset in sleep
         if (asleep_q) begin
            status_q[CSFR_WDOG_BIT] <= 1'b1;
         end
      end else if (sleep_op_i) begin
         // (RULE7) sleep clears sleep flag
         status_q[CSFR_SLEEP_BIT] <= 1'b0;
         status_q[CSFR_WDOG_BIT]  <= 1'b1;
      end else if (watchdog_clear_op_i) begin
         // (RULE7) clear op sets sleep flag
         status_q[CSFR_SLEEP_BIT] <= 1'b1;
         status_q[CSFR_WDOG_BIT]  <= 1'b1;
      end
   end

   // Sleep state, ended by any reset or wake source
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         asleep_q <= 1'b0;
      end else if (wdt_timeout_i || ext_rst_i) begin
         asleep_q <= 1'b0;
      end else if (sleep_op_i) begin
         asleep_q <= 1'b1;
      end
   end

   assign asleep_o            = asleep_q;
   assign program_bank_bits_o = status_q[CSFR_BANK_HI:CSFR_BANK_LO];

   // Indirect pointer; bit 7 is held at one
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pointer_q <= CSFR_POINTER_RST;
      end else if (wr_en && eff_addr[4:0] == CSFR_POINTER_ADDR) begin
         // (RULE12) register select bits
         pointer_q[4:0] <= f_wdata_i[4:0];
         // (RULE13) bank select on big variant
         pointer_q[6:5] <= (NUM_BANKS == 4) ? f_wdata_i[6:5] : 2'b00;
         // (RULE15) read-only one
         pointer_q[CSFR_PTR_FIXED] <= 1'b1;
      end
   end

   // Port latches; 07h stays storage without pins
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         port1_out_q <= CSFR_PORT_RST[3:0];
         port2_q     <= CSFR_PORT_RST;
         port3_q     <= CSFR_PORT_RST;
      end else if (wr_en) begin
         if (eff_addr[4:0] == CSFR_PORT1_ADDR) begin
            port1_out_q <= f_wdata_i[3:0];
         end
         if (eff_addr[4:0] == CSFR_PORT2_ADDR) begin
            port2_q <= f_wdata_i;
         end
         // (RULE20) 07h is storage
         if (eff_addr[4:0] == CSFR_PORT3_ADDR) begin
            port3_q <= f_wdata_i;
         end
      end
   end

   assign second_port_io_o = port2_q;
   assign third_port_io_o  = HAS_PORT3 ? port3_q : 8'h00;

   // Direction register, load operation only
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || hw_reset) begin
         first_port_direction_q <= CSFR_DIR_RST;
      end else if (direction_load_op_i &&
                   dir_addr_i == CSFR_PORT1_ADDR) begin
         // (RULE22) dedicated direction load
         first_port_direction_q <= work_i[3:0];
      end
   end

   // A one in the direction register floats the pin
   // (RULE21) direction sets driver enable
   assign first_port_io_o    = port1_out_q;
   assign first_port_io_oe_o = ~first_port_direction_q;

   // Pin synchroniser; a level counts once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pin_s1_q  <= 4'h0;
         pin_s2_q  <= 4'h0;
         pin_s3_q  <= 4'h0;
         pin_lvl_q <= 4'h0;
      end else begin
         pin_s1_q <= first_port_io_i;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         // (RULE18) filtered pin level
         for (int i = 0; i < 4; i++) begin
            if (pin_s2_q[i] == pin_s3_q[i]) begin
               pin_lvl_q[i] <= pin_s3_q[i];
            end
         end
      end
   end

   // Two-level stack; call wins over a same-cycle return
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         stk1_q        <= '0;
         stk2_q        <= '0;
         pc_load_o     <= 1'b0;
         pc_load_val_o <= '0;
      end else begin
         pc_load_o <= 1'b0;
         if (call_i) begin
            // (RULE2) push, old level two lost
            stk2_q <= stk1_q;
            stk1_q <= pc_i + PC_W'(1);
         end else if (ret_i) begin
            // (RULE1) pop into program counter
            pc_load_o     <= 1'b1;
            pc_load_val_o <= stk1_q;
            stk1_q        <= stk2_q;
            // (RULE23) level two kept
            stk2_q        <= stk2_q;
         end
      end
   end

endmodule : csfr_regs
